// ---- lcd_frame_divider.sv ----
// frame timing package and the row slot divider that steps the backplane rows
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// shared constants for the lcd drive timing
// ****************************************************************
package lcd_timing_pkg;
    localparam int unsigned SEG_COUNT       = 60;          // segment outputs
    localparam int unsigned BP_COUNT        = 4;           // backplane outputs
    localparam int unsigned FRAME_DIV       = 24;          // working ticks per frame
    localparam int unsigned CLK_PERIOD_NS   = 50;          // mclk period
    localparam int unsigned OSC_PERIOD_NS   = 507614;      // nominal oscillator period, 1970 Hz
    // half period in mclk cycles, longest time so rounded down
    localparam int unsigned OSC_HALF_CYCLES = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // drive mode codes from the command decoder
    typedef enum logic [1:0] {
        MODE_STATIC = 2'h0,
        MODE_MUX2   = 2'h1,
        MODE_MUX3   = 2'h2,
        MODE_MUX4   = 2'h3
    } driveMode_t;

    // output level codes handed to the analog selector
    localparam logic [1:0] LVL_VSS  = 2'h0;   // ground
    localparam logic [1:0] LVL_LOW  = 2'h1;   // 1/3 level, or mid level in half bias
    localparam logic [1:0] LVL_HIGH = 2'h2;   // 2/3 level
    localparam logic [1:0] LVL_VLCD = 2'h3;   // full lcd supply

    // reset values
    localparam logic [1:0] RST_LEVEL = LVL_VLCD;
    localparam logic [4:0] RST_SLOT  = 5'h00;
    localparam logic [1:0] RST_ROW   = 2'h0;

    // ticks per row slot: the frame split evenly over the rows in use
    function automatic logic [4:0] slotLength(input logic [1:0] mode);
        case (mode)
            MODE_STATIC: slotLength = 5'(FRAME_DIV);
            MODE_MUX2:   slotLength = 5'(FRAME_DIV / 2);
            MODE_MUX3:   slotLength = 5'(FRAME_DIV / 3);
            default:     slotLength = 5'(FRAME_DIV / 4);
        endcase
    endfunction : slotLength

    // index of the last row in use for a mode
    function automatic logic [1:0] lastRow(input logic [1:0] mode);
        lastRow = mode;
    endfunction : lastRow
endpackage : lcd_timing_pkg

// ****************************************************************
// row slot divider
// ****************************************************************
module lcd_frame_divider (
    input  wire logic       mclk,
    input  wire logic       rstN,       // synchronised reset, active low
    input  wire logic       tick,       // one working clock period elapsed
    input  wire logic       resync,     // cascade frame start seen on sync line
    input  wire logic [1:0] driveMode,
    output logic      [4:0] slotCnt,    // tick within the current row slot
    output logic      [1:0] row,        // active backplane row
    output logic            polarity,   // inverts every frame for dc balance
    output logic            frameWrap   // tick that closes the frame
);
    logic [4:0] next_slotCnt;   // next tick count
    logic [1:0] next_row;       // next row
    logic       next_polarity;  // next polarity
    logic       slotEnd;        // last tick of a row slot

    // ****************************************************************
    // next slot, row and polarity
    // ****************************************************************
    always_comb begin
        next_slotCnt  = slotCnt;
        next_row      = row;
        next_polarity = polarity;
        slotEnd       = (slotCnt >= lcd_timing_pkg::slotLength(driveMode) - 5'h01);
        // row past the last one after a mode change also closes the frame
        frameWrap     = tick && slotEnd && (row >= lcd_timing_pkg::lastRow(driveMode));
        if (resync) begin
            // cascade alignment: restart the frame, keep polarity       [RULE10]
            next_slotCnt = lcd_timing_pkg::RST_SLOT;
            next_row     = lcd_timing_pkg::RST_ROW;
        end else if (frameWrap) begin
            // 24 ticks done: new frame, flip the drive polarity         [RULE9]
            next_slotCnt  = lcd_timing_pkg::RST_SLOT;
            next_row      = lcd_timing_pkg::RST_ROW;
            next_polarity = !polarity;
        end else if (tick && slotEnd) begin
            // equal slots, only the rows the mode uses                  [RULE19]
            next_slotCnt = lcd_timing_pkg::RST_SLOT;
            next_row     = row + 2'h1;
        end else if (tick) begin
            next_slotCnt = slotCnt + 5'h01;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            slotCnt  <= lcd_timing_pkg::RST_SLOT;
            row      <= lcd_timing_pkg::RST_ROW;
            polarity <= 1'b0;
        end else begin
            slotCnt  <= next_slotCnt;
            row      <= next_row;
            polarity <= next_polarity;
        end
    end
endmodule : lcd_frame_divider

`default_nettype wire

// ---- lcd_mux_drive_timing.sv ----
// multiplexed lcd backplane and segment drive timing with clock select and cascade sync
//
// Overview of operation
// [RULE1] levels follow mode-set drive configuration
// [RULE2] two-row mode supports half and third bias
// [RULE3] three and four rows allow half bias
// [RULE4] one working clock times everything
// [RULE5] select pin low runs internal oscillator
// [RULE6] internal clock driven out on clock pin
// [RULE7] select pin high takes clock pin input
// [RULE8] system keeps the clock always running
// [RULE9] frame rate is working clock over 24
// [RULE10] cascade frames aligned through sync pin
// [RULE11] display register holds ram data per frame
// [RULE12] 60 segments from row phase and bit
// [RULE13] four rows: four distinct backplane waveforms
// [RULE14] three rows: backplane 3 copies backplane 1
// [RULE15] two rows: 0/2 and 1/3 pairs equal
// [RULE16] static: all backplanes carry one waveform
// [RULE17] sync pin bidirectional, active low
// [RULE18] ram row k to backplane k, column j to segment j
// [RULE19] equal row slots, only rows in use
// [RULE20] bit one gives on pattern, zero off pattern
`timescale 1ns/1ps
`default_nettype none

module lcd_mux_drive_timing #(
    parameter int unsigned OSC_HALF = lcd_timing_pkg::OSC_HALF_CYCLES  // oscillator half period
) (
    input  wire logic        mclk,          // 20 MHz system clock
    input  wire logic        rst_b,         // asynchronous reset, active low
    input  wire logic        oscSelect,     // pin: low internal oscillator, high external
    input  wire logic        clkIn,         // clock pin, input side
    output logic             clkOut,        // clock pin, output side
    output logic             clkDriveN,     // clock pin enable, low while driving
    input  wire logic        syncIn,        // sync line level, active low
    output logic             syncOut,       // sync line drive value
    output logic             syncDriveN,    // sync line enable, low while pulling low
    input  wire logic [1:0]  driveMode,     // mode from the command decoder
    input  wire logic        halfBias,      // one-half bias when high, one-third when low
    input  wire logic [239:0] ramData,      // display ram, column j row k at bit 4*j+k
    output logic      [7:0]  backplaneOut,  // 4 x 2-bit level codes, bp k at bits 2k+1:2k
    output logic      [119:0] segmentOut,   // 60 x 2-bit level codes, seg j at bits 2j+1:2j
    output logic             frameRate      // toggles once per frame
);
    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    logic       rstMeta;        // reset release, first stage
    logic       rstN;           // reset release, used everywhere
    logic [1:0] oscSelSync;     // oscillator select pin
    logic [2:0] clkSync;        // clock pin, two stages plus edge history
    logic [2:0] syncSync;       // sync line, two stages plus edge history

    // reset is asserted at once and released through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // pins from outside the mclk domain; only stage two onward is read
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            oscSelSync <= 2'h0;
            clkSync    <= 3'h0;
            syncSync   <= 3'h7;
        end else begin
            oscSelSync <= {oscSelSync[0], oscSelect};
            clkSync    <= {clkSync[1:0], clkIn};
            syncSync   <= {syncSync[1:0], syncIn};
        end
    end

    logic externalClk;   // external clock selected
    logic extRise;       // rising edge seen on the clock pin
    logic syncFall;      // falling edge seen on the sync line

    always_comb begin
        externalClk = oscSelSync[1];                   // [RULE5] [RULE7]
        extRise     = clkSync[1] && !clkSync[2];
        syncFall    = !syncSync[1] && syncSync[2];     // [RULE17]
    end

    // ****************************************************************
    // internal oscillator and working clock selection
    // ****************************************************************
    localparam int unsigned OSC_W = $clog2(OSC_HALF + 1);  // oscillator counter width

    logic [OSC_W-1:0] oscCnt;        // cycles into the half period
    logic             oscLevel;      // internal oscillator square wave
    logic [OSC_W-1:0] next_oscCnt;   // next counter value
    logic             next_oscLevel; // next square wave level
    logic             tick;          // one working clock period
    logic             next_clkOut;   // next clock pin value
    logic             next_clkDriveN;// next clock pin enable

    // oscillator runs always so a switch back needs no restart
    always_comb begin
        next_oscCnt   = oscCnt + OSC_W'(1);
        next_oscLevel = oscLevel;
        if (oscCnt >= OSC_W'(OSC_HALF - 1)) begin
            next_oscCnt   = '0;
            next_oscLevel = !oscLevel;
        end
        // one tick per working period from whichever source is chosen  [RULE4]
        if (externalClk) begin
            tick = extRise;                                            // [RULE7]
        end else begin
            tick = (oscCnt >= OSC_W'(OSC_HALF - 1)) && !oscLevel;      // [RULE5]
        end
        // pin drives our clock only on the internal source              [RULE6]
        next_clkOut    = externalClk ? 1'b0 : oscLevel;
        next_clkDriveN = externalClk;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            oscCnt    <= '0;
            oscLevel  <= 1'b0;
            clkOut    <= 1'b0;
            clkDriveN <= 1'b1;
        end else begin
            oscCnt    <= next_oscCnt;
            oscLevel  <= next_oscLevel;
            clkOut    <= next_clkOut;
            clkDriveN <= next_clkDriveN;
        end
    end

    // ****************************************************************
    // frame and row slot timing
    // ****************************************************************
    logic [4:0] slotCnt;    // tick within row slot
    logic [1:0] row;        // active row
    logic       polarity;   // frame polarity
    logic       frameWrap;  // last tick of the frame

    // a missing clock simply stops the ticks; outputs then hold level   [RULE8]
    lcd_frame_divider frameDiv (
        .mclk      (mclk),
        .rstN      (rstN),
        .tick      (tick),
        .resync    (syncFall),
        .driveMode (driveMode),
        .slotCnt   (slotCnt),
        .row       (row),
        .polarity  (polarity),
        .frameWrap (frameWrap)
    );

    // ****************************************************************
    // level selection functions
    // ****************************************************************
    // ram row shown on backplane k in each mode
    function automatic logic [1:0] bpRow(input logic [1:0] mode, input logic [1:0] k);
        case (mode)
            lcd_timing_pkg::MODE_STATIC: bpRow = 2'h0;                  // [RULE16]
            lcd_timing_pkg::MODE_MUX2:   bpRow = {1'b0, k[0]};          // [RULE15]
            lcd_timing_pkg::MODE_MUX3:   bpRow = (k == 2'h3) ? 2'h1 : k;// [RULE14]
            default:                     bpRow = k;                     // [RULE13] [RULE18]
        endcase
    endfunction : bpRow

    // backplane level for a selected or idle row
    function automatic logic [1:0] bpLevel(input logic sel, input logic pol,
                                           input logic stat, input logic half);
        if (stat || sel) begin
            bpLevel = pol ? lcd_timing_pkg::LVL_VLCD : lcd_timing_pkg::LVL_VSS;
        end else if (half) begin
            bpLevel = lcd_timing_pkg::LVL_LOW;                          // [RULE2] [RULE3]
        end else begin
            bpLevel = pol ? lcd_timing_pkg::LVL_LOW : lcd_timing_pkg::LVL_HIGH;
        end
    endfunction : bpLevel

    // segment level: on drives opposite the selected backplane
    function automatic logic [1:0] segLevel(input logic on, input logic pol,
                                            input logic stat, input logic half);
        if (on) begin
            segLevel = pol ? lcd_timing_pkg::LVL_VSS : lcd_timing_pkg::LVL_VLCD;
        end else if (stat || half) begin
            segLevel = pol ? lcd_timing_pkg::LVL_VLCD : lcd_timing_pkg::LVL_VSS;
        end else begin
            segLevel = pol ? lcd_timing_pkg::LVL_HIGH : lcd_timing_pkg::LVL_LOW;
        end
    endfunction : segLevel

    // ****************************************************************
    // display register and drive outputs
    // ****************************************************************
    logic [239:0] displayReg;        // ram copy held for the whole frame
    logic [239:0] next_displayReg;   // next display register
    logic [7:0]   next_backplaneOut; // next backplane levels
    logic [119:0] next_segmentOut;   // next segment levels
    logic         next_syncOut;      // next sync drive value
    logic         next_syncDriveN;   // next sync enable
    logic         frameStart;        // first tick of a frame
    logic         statMode;          // static drive selected
    logic         halfSel;           // half bias in effect

    always_comb begin
        statMode = (driveMode == lcd_timing_pkg::MODE_STATIC);
        // static drive has only two levels, bias choice has no meaning there
        halfSel  = halfBias && !statMode;
        frameStart = (row == lcd_timing_pkg::RST_ROW) && (slotCnt == lcd_timing_pkg::RST_SLOT);
        // load at the frame edge so a frame never mixes old and new data [RULE11]
        next_displayReg = frameWrap ? ramData : displayReg;
        // backplanes follow the mode-set configuration                   [RULE1]
        for (int k = 0; k < lcd_timing_pkg::BP_COUNT; k++) begin
            next_backplaneOut[2*k +: 2] = bpLevel(bpRow(driveMode, 2'(k)) == row,
                                                  polarity, statMode, halfSel);
        end
        // segment j from its column bit in the active row                [RULE12] [RULE18]
        for (int j = 0; j < lcd_timing_pkg::SEG_COUNT; j++) begin
            next_segmentOut[2*j +: 2] = segLevel(displayReg[4*j + int'(row)],
                                                 polarity, statMode, halfSel); // [RULE20]
        end
        // open drain: pull the line low during the first tick of a frame [RULE10] [RULE17]
        next_syncOut    = 1'b0;
        next_syncDriveN = !frameStart;
    end

    // levels stay at full supply until the first row slot is computed
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            displayReg   <= '0;
            backplaneOut <= {lcd_timing_pkg::BP_COUNT{lcd_timing_pkg::RST_LEVEL}};
            segmentOut   <= {lcd_timing_pkg::SEG_COUNT{lcd_timing_pkg::RST_LEVEL}};
            syncOut      <= 1'b0;
            syncDriveN   <= 1'b1;
            frameRate    <= 1'b0;
        end else begin
            displayReg   <= next_displayReg;
            backplaneOut <= next_backplaneOut;
            segmentOut   <= next_segmentOut;
            syncOut      <= next_syncOut;
            syncDriveN   <= next_syncDriveN;
            frameRate    <= polarity;                                  // [RULE9]
        end
    end
endmodule : lcd_mux_drive_timing

`default_nettype wire

// ---- lcd_mux_drive_timing_monitor.sv ----
// assertion checker for the lcd drive timing block
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// checker
// ****************************************************************
module lcd_mux_drive_timing_monitor #(
    parameter int unsigned OSC_HALF = lcd_timing_pkg::OSC_HALF_CYCLES  // half period in mclk
) (
    input wire logic         mclk,
    input wire logic         rst_b,
    input wire logic         oscSelect,
    input wire logic         clkIn,
    input wire logic         clkOut,
    input wire logic         clkDriveN,
    input wire logic         syncIn,
    input wire logic         syncOut,
    input wire logic         syncDriveN,
    input wire logic [1:0]   driveMode,
    input wire logic         halfBias,
    input wire logic [239:0] ramData,
    input wire logic [7:0]   backplaneOut,
    input wire logic [119:0] segmentOut,
    input wire logic         frameRate
);
    localparam int FRAME_MCLK = 48 * OSC_HALF;  // 24 ticks of 2*OSC_HALF
    logic [15:0] lowCnt;    // cycles the sync enable stayed low
    logic [23:0] frameCnt;  // cycles since the last frame flip
    logic        prevFr;    // frame flag one cycle ago
    logic [1:0]  prevMode;  // mode one cycle ago
    logic        seen;      // a clean internal frame start was seen
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // helper counters; seen drops on mode, source or foreign sync change: frames may be cut short
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt   <= 16'h0000;
            frameCnt <= 24'h000000;
            prevFr   <= 1'b0;
            prevMode <= 2'h0;
            seen     <= 1'b0;
        end else begin
            lowCnt   <= syncDriveN ? 16'h0000 : lowCnt + 16'h0001;
            frameCnt <= (frameRate != prevFr) ? 24'h000000 : frameCnt + 24'h000001;
            prevFr   <= frameRate;
            prevMode <= driveMode;
            seen     <= ~oscSelect & (driveMode == prevMode) & (syncIn | ~syncDriveN)
                        & (seen | (frameRate != prevFr));
        end
    end
    AST_STATIC_SAME: assert property (driveMode == 2'h0 && $past(driveMode) == 2'h0 |->
        (backplaneOut[1:0] == backplaneOut[3:2]) && (backplaneOut[5:4] == backplaneOut[7:6])
        && (backplaneOut[1:0] == backplaneOut[5:4])) else $error("static backplanes differ");
    AST_MUX2_PAIRS: assert property (driveMode == 2'h1 && $past(driveMode) == 2'h1 |->
        (backplaneOut[1:0] == backplaneOut[5:4]) && (backplaneOut[3:2] == backplaneOut[7:6]))
        else $error("two-row backplane pairs differ");
    AST_MUX3_COPY: assert property ((driveMode == 2'h2) && ($past(driveMode) == 2'h2) |->
        backplaneOut[7:6] == backplaneOut[3:2]) else $error("backplane 3 not a copy of 1");
    AST_OSC_INT: assert property (!oscSelect [*8] |-> !clkDriveN)
        else $error("clock pin not driven on internal oscillator");
    AST_OSC_EXT: assert property (oscSelect [*8] |-> clkDriveN && !clkOut)
        else $error("clock pin driven on external clock");
    AST_SYNC_OPEN_DRAIN: assert property (syncOut == 1'b0)
        else $error("sync line driven high");
    AST_FRAME_SYNC: assert property ($changed(frameRate) |-> $fell(syncDriveN))
        else $error("frame start without sync pulse");
    AST_SYNC_WIDTH: assert property ($rose(syncDriveN) && seen && !oscSelect |->
        lowCnt == 16'(2 * OSC_HALF)) else $error("sync pulse not one tick long");
    AST_FRAME_LEN: assert property ((frameRate != prevFr) && seen |->
        frameCnt == 24'(FRAME_MCLK - 1)) else $error("frame not 24 ticks long");
endmodule : lcd_mux_drive_timing_monitor

bind lcd_mux_drive_timing lcd_mux_drive_timing_monitor #(.OSC_HALF(OSC_HALF)) u_monitor (
    .mclk(mclk), .rst_b(rst_b), .oscSelect(oscSelect), .clkIn(clkIn), .clkOut(clkOut),
    .clkDriveN(clkDriveN), .syncIn(syncIn), .syncOut(syncOut), .syncDriveN(syncDriveN),
    .driveMode(driveMode), .halfBias(halfBias), .ramData(ramData),
    .backplaneOut(backplaneOut), .segmentOut(segmentOut), .frameRate(frameRate));
`default_nettype wire

// ---- lcd_cascade_peer.sv ----
// model of a cascaded partner driver sharing the clock and sync pins
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// cascade peer
// ****************************************************************
module lcd_cascade_peer #(
    parameter real EXT_HALF = 237.0  // peer clock half period, unrelated to mclk
) (
    input  wire logic clkOut,     // device clock pin value
    input  wire logic clkDriveN,  // device clock pin enable, low drives
    input  wire logic syncOut,    // device sync drive value
    input  wire logic syncDriveN, // device sync enable, low pulls
    input  wire logic pullReq,    // bench asks the peer to pull sync low
    output logic      clkPin,     // resolved clock pin
    output logic      syncLine    // resolved sync line, pulled up
);
    logic peerClk = 1'b0;  // peer never stops its clock
    // free running source so the lcd never sits at dc
    always #(EXT_HALF) peerClk = ~peerClk;
    // device wins the pin while it drives it
    assign clkPin = clkDriveN ? peerClk : clkOut;
    // open drain, either party may pull low
    assign syncLine = ~((~syncDriveN & ~syncOut) | pullReq);
endmodule : lcd_cascade_peer
`default_nettype wire

// ---- lcd_mux_drive_timing_tb.sv ----
// self-checking testbench for the lcd drive timing block
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// testbench
// ****************************************************************
module lcd_mux_drive_timing_tb;
    localparam int OSC_HALF = 4;             // short oscillator for simulation
    localparam int TICK     = 2 * OSC_HALF;  // mclk per working tick
    logic         mclk = 1'b0;
    logic         rst_b, oscSelect, pullReq, halfBias;
    logic [1:0]   driveMode;
    logic [239:0] ramData;
    logic         clkIn, clkOut, clkDriveN, syncIn, syncOut, syncDriveN, frameRate;
    logic [7:0]   backplaneOut;
    logic [119:0] segmentOut;
    int           numErrors = 0;  // mismatches
    int           nTests    = 0;  // comparisons
    always #25 mclk = ~mclk;  // 20 MHz
    lcd_mux_drive_timing #(.OSC_HALF(OSC_HALF)) u_dut (.mclk(mclk), .rst_b(rst_b),
        .oscSelect(oscSelect), .clkIn(clkIn), .clkOut(clkOut), .clkDriveN(clkDriveN),
        .syncIn(syncIn), .syncOut(syncOut), .syncDriveN(syncDriveN), .driveMode(driveMode),
        .halfBias(halfBias), .ramData(ramData), .backplaneOut(backplaneOut),
        .segmentOut(segmentOut), .frameRate(frameRate));
    lcd_cascade_peer u_peer (.clkOut(clkOut), .clkDriveN(clkDriveN), .syncOut(syncOut),
        .syncDriveN(syncDriveN), .pullReq(pullReq), .clkPin(clkIn), .syncLine(syncIn));
    // one comparison, counted
    task automatic cmp(input logic ok, input string msg);
        nTests++;
        if (ok !== 1'b1) begin
            numErrors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : cmp
    // wait for the frame flag to flip, bounded
    task automatic waitFrame();
        logic f;
        int   n;
        f = frameRate;
        n = 0;
        while (frameRate === f && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        cmp(n < 2000, "frame flag stuck");
    endtask : waitFrame
    // display image that differs per seed
    function automatic logic [239:0] makeRam(input int s);
        for (int b = 0; b < 240; b++) makeRam[b] = ((b / 4 + 2 * (b % 4) + s) % 3) == 0;
    endfunction : makeRam
    // one full frame of levels for a mode and bias
    task automatic test_mode(input logic [1:0] mode, input logic half);
        int           slot, r, lrow;
        logic         p;
        logic [1:0]   sel, idle, on, off, e;
        logic [239:0] img;
        driveMode = mode;
        halfBias  = half;
        img       = makeRam(mode * 2 + half);
        ramData   = img;
        waitFrame();
        waitFrame();
        ramData = ~img;  // mid-frame write, must wait for the next frame
        repeat (OSC_HALF) @(negedge mclk);
        slot = 24 / (mode + 1);
        for (int k = 0; k < 24; k++) begin
            r    = k / slot;
            p    = frameRate;
            sel  = p ? 2'h3 : 2'h0;
            idle = half ? 2'h1 : (p ? 2'h1 : 2'h2);
            on   = p ? 2'h0 : 2'h3;
            off  = (half || mode == 2'h0) ? (p ? 2'h3 : 2'h0) : (p ? 2'h2 : 2'h1);
            for (int i = 0; i < 4; i++) begin
                lrow = !mode ? 0 : (mode == 2'h1) ? i % 2 : (mode == 2'h2 && i == 3) ? 1 : i;
                e    = (lrow == r) ? sel : idle;
                cmp(backplaneOut[2*i +: 2] === e, "bp level");
            end
            for (int j = 0; j < 60; j++) begin
                e = img[4*j + r] ? on : off;
                cmp(segmentOut[2*j +: 2] === e, "segment level");
            end
            repeat (TICK) @(negedge mclk);
        end
        $display("test_mode %0d half %0d done", mode, half);
    endtask : test_mode
    // clock source, pin direction and frame division
    task automatic test_clock(input logic ext);
        int   rises, cyc;
        logic last, f;
        oscSelect = ext;
        waitFrame();
        waitFrame();
        cmp(clkDriveN === ext, "clock pin direction");
        rises = 0;
        cyc   = 0;
        last  = clkIn;
        f     = frameRate;
        while (frameRate === f && cyc < 4000) begin
            @(negedge mclk);
            cyc++;
            if (clkIn && !last) rises++;
            last = clkIn;
        end
        cmp(rises == 24, "working clock edges per frame");
        if (!ext) cmp(cyc == 24 * TICK, "frame length in mclk");
        $display("test_clock ext %0d done", ext);
    endtask : test_clock
    // peer pulls sync mid frame, frame restarts at row 0
    task automatic test_sync();
        driveMode = 2'h3;
        halfBias  = 1'b0;
        waitFrame();
        waitFrame();
        cmp(syncIn === 1'b0, "sync line low at frame start");
        repeat (100) @(negedge mclk);
        pullReq = 1'b1;
        repeat (4) @(negedge mclk);
        pullReq = 1'b0;
        repeat (4) @(negedge mclk);
        cmp(backplaneOut[1:0] === (frameRate ? 2'h3 : 2'h0), "row 0 after resync");
        cmp(backplaneOut[3:2] !== backplaneOut[1:0], "row 1 idle after resync");
        $display("test_sync done");
    endtask : test_sync
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        rst_b     = 1'b0;
        oscSelect = 1'b0;
        pullReq   = 1'b0;
        driveMode = 2'h3;
        halfBias  = 1'b0;
        ramData   = '0;
        repeat (3) @(negedge mclk);
        cmp(backplaneOut === 8'hff && segmentOut === '1, "reset levels");
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        for (int m = 0; m < 4; m++) for (int h = 0; h < 2; h++) test_mode(2'(m), 1'(h));
        test_clock(1'b0);
        test_clock(1'b1);
        test_sync();
        wrap_up();
    end
    // watchdog, well beyond the roughly 6500 cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk);
        numErrors++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : lcd_mux_drive_timing_tb
`default_nettype wire
